// ==== src/fsps_sequencer.sv ====
// module: flash self-program sequencer with wishbone register slave
// Contract
// - opsel code 110 selects unlock mode
// - arm bit in unlock mode starts timer
// - timer expiry clears arm bit always
// - matching key sets enabled flag, else not
// - clearing enabled flag revokes permission at once, unless an armed key match in unlock mode sets it again
// - 32-word page buffer, page from address 12:5
// - low byte first; high byte loads, increments
// - buffer address saturates at last page word
// - code 001 erases tagged page on go
// - code 000 writes buffer into page on go
// - go starts operation, hardware clears on done
// - cpu stalled while operation runs
// - duration select sets go high time
// - buffer clear bit self-clears when clear done
// - low write stores byte; high commits word
// - dummy high writes tag, stop at 11111b
`timescale 1ns/10ps
module fsps_sequencer #(
  parameter int ERASE_SHORT = fsps_pkg::ERASE_SHORT_CYC,
  parameter int ERASE_LONG = fsps_pkg::ERASE_LONG_CYC,
  parameter int WRITE_SHORT = fsps_pkg::WRITE_SHORT_CYC,
  parameter int WRITE_LONG = fsps_pkg::WRITE_LONG_CYC,
  parameter int UNLOCK_WIN = fsps_pkg::UNLOCK_WIN_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flash array side
  output logic flashErase,
  output logic flashProgram,
  output logic [12:0] flashAddr,
  output logic [31:0] tagMask,
  // cpu hold
  output logic cpuStall
);
  // ==========================================================
  // state
  fsps_pkg::fsps_state_t state_r, state_nxt;
  logic [2:0] opsel_r, opsel_nxt; // operation select
  logic arm_r, arm_nxt; // unlock arm
  logic go_r, go_nxt; // program go
  logic enabled_r, enabled_nxt; // erase/write permission
  logic dursel_r, dursel_nxt; // duration select
  logic bufclr_r, bufclr_nxt; // buffer clear request
  logic [12:0] addr_r, addr_nxt; // address pair
  logic [7:0] wordLow_r, wordLow_nxt; // low staging byte
  logic [7:0] wordHigh_r, wordHigh_nxt; // last high byte
  logic [7:0] key_r [6]; // key registers
  logic [7:0] key_nxt [6];
  logic [31:0] tag_r, tag_nxt; // tagged offsets
  logic [31:0] timer_r, timer_nxt; // shared down counter
  logic [4:0] clrIdx_r, clrIdx_nxt; // clear walk index
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic erase_r, erase_nxt, prog_r, prog_nxt;
  logic stall_r, stall_nxt; // cpu hold, registered for a clean output
  // bus decode
  logic req, wr, lane0;
  logic [7:0] wb0;
  logic keyOk;
  logic goSet; // go bit written in this cycle
  // buffer link
  fsps_buf_if bufp ();
  fsps_page_buf u_buf (
    .mclk(mclk),
    .bus(bufp.mem)
  );
  // ==========================================================
  // decode; one-cycle answer, ack drops after one cycle
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i;
  assign lane0 = wb_sel_i[0];
  assign wb0 = wb_dat_i[7:0];
  assign goSet = wr && lane0 && wb_adr_i == fsps_pkg::OFS_CTRL_PRIMARY
    && wb0[fsps_pkg::POS_GO];
  assign keyOk = key_r[0] == fsps_pkg::KEY_L2
    && key_r[2] == fsps_pkg::KEY_L3
    && key_r[4] == fsps_pkg::KEY_L4
    && key_r[1] == fsps_pkg::KEY_H2
    && key_r[3] == fsps_pkg::KEY_H3
    && key_r[5] == fsps_pkg::KEY_H4;
  // ==========================================================
  // next-state logic for all control state
  always_comb begin
    state_nxt = state_r;
    opsel_nxt = opsel_r;
    arm_nxt = arm_r;
    go_nxt = go_r;
    enabled_nxt = enabled_r;
    dursel_nxt = dursel_r;
    bufclr_nxt = bufclr_r;
    addr_nxt = addr_r;
    wordLow_nxt = wordLow_r;
    wordHigh_nxt = wordHigh_r;
    key_nxt = key_r;
    tag_nxt = tag_r;
    timer_nxt = timer_r;
    clrIdx_nxt = clrIdx_r;
    ack_nxt = req;
    rdat_nxt = 32'h0;
    erase_nxt = 1'b0;
    prog_nxt = 1'b0;
    bufp.wrEn = 1'b0;
    bufp.wrAddr = addr_r[4:0];
    bufp.wrData = {wb0, wordLow_r};
    // register reads; unmapped offsets read zero
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        fsps_pkg::OFS_CTRL_PRIMARY: begin
          rdat_nxt[fsps_pkg::POS_OPSEL +: 3] = opsel_r;
          rdat_nxt[fsps_pkg::POS_ARM] = arm_r;
          rdat_nxt[fsps_pkg::POS_GO] = go_r;
          rdat_nxt[fsps_pkg::POS_ENABLED] = enabled_r;
        end
        fsps_pkg::OFS_CTRL_THIRD: begin
          rdat_nxt[fsps_pkg::POS_DURSEL] = dursel_r;
          rdat_nxt[fsps_pkg::POS_BUFCLR] = bufclr_r;
        end
        fsps_pkg::OFS_ADDR_LOW: rdat_nxt[7:0] = addr_r[7:0];
        fsps_pkg::OFS_ADDR_HIGH: rdat_nxt[4:0] = addr_r[12:8];
        fsps_pkg::OFS_WORD_LOW: rdat_nxt[7:0] = wordLow_r;
        fsps_pkg::OFS_WORD_HIGH: rdat_nxt[7:0] = wordHigh_r;
        fsps_pkg::OFS_KEY_LOW2: rdat_nxt[7:0] = key_r[0];
        fsps_pkg::OFS_KEY_HIGH2: rdat_nxt[7:0] = key_r[1];
        fsps_pkg::OFS_KEY_LOW3: rdat_nxt[7:0] = key_r[2];
        fsps_pkg::OFS_KEY_HIGH3: rdat_nxt[7:0] = key_r[3];
        fsps_pkg::OFS_KEY_LOW4: rdat_nxt[7:0] = key_r[4];
        fsps_pkg::OFS_KEY_HIGH4: rdat_nxt[7:0] = key_r[5];
        default: rdat_nxt = 32'h0;
      endcase
    end
    // register writes; taken in SEQ_IDLE only, so writes while clearing or busy are acked and dropped
    if (wr && lane0 && state_r == fsps_pkg::SEQ_IDLE) begin
      unique case (wb_adr_i)
        fsps_pkg::OFS_CTRL_PRIMARY: begin
          opsel_nxt = wb0[fsps_pkg::POS_OPSEL +: 3];
          // clearing allowed unless an armed key match in unlock mode below sets it again; setting never by write
          if (!wb0[fsps_pkg::POS_ENABLED]) begin
            enabled_nxt = 1'b0;
          end
          if (wb0[fsps_pkg::POS_ARM] && !arm_r
              && wb0[fsps_pkg::POS_OPSEL +: 3] == fsps_pkg::OP_UNLOCK)
              begin
            arm_nxt = 1'b1;
            timer_nxt = 32'(UNLOCK_WIN);
          end
          if (wb0[fsps_pkg::POS_GO]) begin
            go_nxt = 1'b1;
          end
        end
        fsps_pkg::OFS_CTRL_THIRD: begin
          dursel_nxt = wb0[fsps_pkg::POS_DURSEL];
          if (wb0[fsps_pkg::POS_BUFCLR]) begin
            bufclr_nxt = 1'b1;
          end
        end
        fsps_pkg::OFS_ADDR_LOW: addr_nxt[7:0] = wb0;
        fsps_pkg::OFS_ADDR_HIGH: addr_nxt[12:8] = wb0[4:0];
        fsps_pkg::OFS_WORD_LOW: wordLow_nxt = wb0;
        fsps_pkg::OFS_WORD_HIGH: begin
          wordHigh_nxt = wb0;
          bufp.wrEn = 1'b1;
          tag_nxt[addr_r[4:0]] = 1'b1;
          if (addr_r[4:0] != fsps_pkg::LAST_OFS) begin
            addr_nxt[4:0] = addr_r[4:0] + 5'h01;
          end
        end
        fsps_pkg::OFS_KEY_LOW2: key_nxt[0] = wb0;
        fsps_pkg::OFS_KEY_HIGH2: key_nxt[1] = wb0;
        fsps_pkg::OFS_KEY_LOW3: key_nxt[2] = wb0;
        fsps_pkg::OFS_KEY_HIGH3: key_nxt[3] = wb0;
        fsps_pkg::OFS_KEY_LOW4: key_nxt[4] = wb0;
        fsps_pkg::OFS_KEY_HIGH4: key_nxt[5] = wb0;
        default: addr_nxt = addr_r; // unmapped writes ignored
      endcase
    end
    // unlock window: compare while armed only
    if (arm_r) begin
      if (keyOk && opsel_r == fsps_pkg::OP_UNLOCK) begin
        enabled_nxt = 1'b1;
      end
      if (timer_r <= 32'h1) begin
        arm_nxt = 1'b0;
      end else begin
        timer_nxt = timer_r - 32'h1;
      end
    end
    // sequencer
    unique case (state_r)
      fsps_pkg::SEQ_IDLE: begin
        if (bufclr_r) begin
          state_nxt = fsps_pkg::SEQ_CLEAR;
          clrIdx_nxt = 5'h00;
        end else if (go_r) begin
          if (!enabled_r || (opsel_r != fsps_pkg::OP_ERASE
              && opsel_r != fsps_pkg::OP_WRITE)) begin
            // a fresh go written in this cycle wins over the drop
            go_nxt = goSet;
          end else begin
            state_nxt = fsps_pkg::SEQ_BUSY;
            if (opsel_r == fsps_pkg::OP_ERASE) begin
              erase_nxt = 1'b1;
              timer_nxt = 32'(dursel_r ? ERASE_LONG : ERASE_SHORT);
            end else begin
              prog_nxt = 1'b1;
              timer_nxt = 32'(dursel_r ? WRITE_LONG : WRITE_SHORT);
            end
          end
        end
      end
      fsps_pkg::SEQ_CLEAR: begin
        // blank every word, one per cycle; tags cleared too
        bufp.wrEn = 1'b1;
        bufp.wrAddr = clrIdx_r;
        bufp.wrData = 16'h0000;
        tag_nxt = 32'h0;
        clrIdx_nxt = clrIdx_r + 5'h01;
        if (clrIdx_r == fsps_pkg::LAST_OFS) begin
          bufclr_nxt = 1'b0;
          state_nxt = fsps_pkg::SEQ_IDLE;
        end
      end
      fsps_pkg::SEQ_BUSY: begin
        erase_nxt = erase_r;
        prog_nxt = prog_r;
        if (timer_r <= 32'h1) begin
          go_nxt = 1'b0;
          erase_nxt = 1'b0;
          prog_nxt = 1'b0;
          tag_nxt = 32'h0;
          state_nxt = fsps_pkg::SEQ_IDLE;
        end else begin
          timer_nxt = timer_r - 32'h1;
        end
      end
    endcase
    // stall follows the operation strobes exactly
    stall_nxt = erase_nxt | prog_nxt;
  end
  assign bufp.rdAddr = 5'h00;
  // ==========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= fsps_pkg::SEQ_IDLE;
      opsel_r <= 3'h0;
      arm_r <= 1'b0;
      go_r <= 1'b0;
      enabled_r <= 1'b0;
      dursel_r <= 1'b0;
      bufclr_r <= 1'b0;
      addr_r <= 13'h0;
      wordLow_r <= 8'h0;
      wordHigh_r <= 8'h0;
      for (int i = 0; i < 6; i++) begin
        key_r[i] <= 8'h0;
      end
      tag_r <= 32'h0;
      timer_r <= 32'h0;
      clrIdx_r <= 5'h0;
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
      erase_r <= 1'b0;
      prog_r <= 1'b0;
      stall_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      opsel_r <= opsel_nxt;
      arm_r <= arm_nxt;
      go_r <= go_nxt;
      enabled_r <= enabled_nxt;
      dursel_r <= dursel_nxt;
      bufclr_r <= bufclr_nxt;
      addr_r <= addr_nxt;
      wordLow_r <= wordLow_nxt;
      wordHigh_r <= wordHigh_nxt;
      key_r <= key_nxt;
      tag_r <= tag_nxt;
      timer_r <= timer_nxt;
      clrIdx_r <= clrIdx_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      erase_r <= erase_nxt;
      prog_r <= prog_nxt;
      stall_r <= stall_nxt;
    end
  end
  // ==========================================================
  // outputs straight from flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign flashErase = erase_r;
  assign flashProgram = prog_r;
  assign flashAddr = {addr_r[12:5], 5'h00};
  assign tagMask = tag_r;
  assign cpuStall = stall_r;
endmodule : fsps_sequencer

// ==== src/fsps_pkg.sv ====
// package: register map, field positions and timing for the flash sequencer
package fsps_pkg;
  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [5:0] OFS_CTRL_PRIMARY = 6'h00;
  localparam logic [5:0] OFS_CTRL_THIRD = 6'h08;
  localparam logic [5:0] OFS_ADDR_LOW = 6'h0c;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h10;
  localparam logic [5:0] OFS_WORD_LOW = 6'h14;
  localparam logic [5:0] OFS_WORD_HIGH = 6'h18;
  localparam logic [5:0] OFS_KEY_LOW2 = 6'h1c;
  localparam logic [5:0] OFS_KEY_HIGH2 = 6'h20;
  localparam logic [5:0] OFS_KEY_LOW3 = 6'h24;
  localparam logic [5:0] OFS_KEY_HIGH3 = 6'h28;
  localparam logic [5:0] OFS_KEY_LOW4 = 6'h2c;
  localparam logic [5:0] OFS_KEY_HIGH4 = 6'h30;
  // ==========================================================
  // primary control fields
  localparam int POS_OPSEL = 4;
  localparam int POS_ARM = 3;
  localparam int POS_GO = 2;
  localparam int POS_ENABLED = 0;
  // third control fields
  localparam int POS_DURSEL = 1;
  localparam int POS_BUFCLR = 0;
  // ==========================================================
  // operation select codes
  localparam logic [2:0] OP_WRITE = 3'h0;
  localparam logic [2:0] OP_ERASE = 3'h1;
  localparam logic [2:0] OP_UNLOCK = 3'h6;
  // key pattern, low2..low4 then high2..high4
  localparam logic [7:0] KEY_L2 = 8'h00;
  localparam logic [7:0] KEY_L3 = 8'h0d;
  localparam logic [7:0] KEY_L4 = 8'hc3;
  localparam logic [7:0] KEY_H2 = 8'h04;
  localparam logic [7:0] KEY_H3 = 8'h09;
  localparam logic [7:0] KEY_H4 = 8'h40;
  // ==========================================================
  // buffer geometry
  localparam int BUF_DEPTH = 32;
  localparam int BUF_AW = 5;
  localparam logic [4:0] LAST_OFS = 5'h1f;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int ERASE_SHORT_US = 3200;
  localparam int ERASE_LONG_US = 3700;
  localparam int WRITE_SHORT_US = 2200;
  localparam int WRITE_LONG_US = 3000;
  localparam int UNLOCK_WIN_US = 1000;
  localparam int ERASE_SHORT_CYC = ERASE_SHORT_US * CLK_MHZ;
  localparam int ERASE_LONG_CYC = ERASE_LONG_US * CLK_MHZ;
  localparam int WRITE_SHORT_CYC = WRITE_SHORT_US * CLK_MHZ;
  localparam int WRITE_LONG_CYC = WRITE_LONG_US * CLK_MHZ;
  localparam int UNLOCK_WIN_CYC = UNLOCK_WIN_US * CLK_MHZ;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CLEAR,
    SEQ_BUSY
  } fsps_state_t;
endpackage : fsps_pkg

// ==== src/fsps_buf_if.sv ====
// interface: write-buffer port between sequencer and buffer memory
`timescale 1ns/10ps
interface fsps_buf_if;
  logic wrEn; // store one word
  logic [4:0] wrAddr; // word offset in page
  logic [15:0] wrData; // word value
  logic [4:0] rdAddr; // read offset
  logic [15:0] rdData; // registered read word
  modport ctrl (output wrEn, output wrAddr, output wrData,
    output rdAddr, input rdData);
  modport mem (input wrEn, input wrAddr, input wrData,
    input rdAddr, output rdData);
endinterface : fsps_buf_if

// ==== src/fsps_page_buf.sv ====
// module: 32-word page write buffer with registered read
`timescale 1ns/10ps
module fsps_page_buf (
  // clock
  input wire logic mclk,
  // buffer port
  fsps_buf_if.mem bus
);
  // ==========================================================
  // storage
  logic [15:0] mem [fsps_pkg::BUF_DEPTH]; // page words
  logic [15:0] rdData_r; // read register
  logic [15:0] rdData_nxt;
  // read path computed here, registered below
  always_comb begin
    rdData_nxt = mem[bus.rdAddr];
  end
  // memory write and read register
  always_ff @(posedge mclk) begin
    if (bus.wrEn) begin
      mem[bus.wrAddr] <= bus.wrData;
    end
    rdData_r <= rdData_nxt;
  end
  assign bus.rdData = rdData_r;
endmodule : fsps_page_buf

// ==== verification/fsps_sequencer_monitor.sv ====
// checker: bus answer and array-side timing of the flash sequencer
`timescale 1ns/10ps
module fsps_seq_monitor #(
  parameter int ERASE_SHORT = 20,
  parameter int ERASE_LONG = 30,
  parameter int WRITE_SHORT = 10,
  parameter int WRITE_LONG = 15
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // array side
  input wire logic flashErase,
  input wire logic flashProgram,
  input wire logic [12:0] flashAddr,
  input wire logic [31:0] tagMask,
  input wire logic cpuStall
);
  // ==========================================================
  // helper: cycles the current operation has run
  int opLen_r; // counted high cycles
  int opLen_nxt; // next count
  // zero while idle, so the count at the fall is the length
  always_comb begin
    opLen_nxt = (flashErase | flashProgram) ? opLen_r + 1 : 0;
  end
  always_ff @(posedge mclk) begin
    opLen_r <= reset ? 0 : opLen_nxt;
  end
  // ==========================================================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
  AST_RD_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_STALL: assert property (
    cpuStall == (flashErase | flashProgram))
    else $error("stall not tied to operation");
  AST_ONE_OP: assert property (
    !(flashErase && flashProgram))
    else $error("erase and program together");
  AST_ERASE_LEN: assert property (
    $fell(flashErase) |-> opLen_r == ERASE_SHORT || opLen_r == ERASE_LONG)
    else $error("erase length wrong");
  AST_WRITE_LEN: assert property (
    $fell(flashProgram) |-> opLen_r == WRITE_SHORT || opLen_r == WRITE_LONG)
    else $error("write length wrong");
  AST_PAGE_BASE: assert property (flashAddr[4:0] == 5'h0)
    else $error("address not page aligned");
  AST_OP_STABLE: assert property (
    cpuStall && $past(cpuStall) |-> $stable(flashAddr) && $stable(tagMask))
    else $error("page or tags moved mid operation");
endmodule : fsps_seq_monitor
bind fsps_sequencer fsps_seq_monitor #(.ERASE_SHORT(ERASE_SHORT),
  .ERASE_LONG(ERASE_LONG), .WRITE_SHORT(WRITE_SHORT),
  .WRITE_LONG(WRITE_LONG)) u_mon (.mclk(mclk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .flashErase(flashErase),
  .flashProgram(flashProgram), .flashAddr(flashAddr),
  .tagMask(tagMask), .cpuStall(cpuStall));

// ==== verification/fsps_sequencer_tb_top.sv ====
// testbench: register-level scenarios for the flash sequencer
`timescale 1ns/10ps
module fsps_sequencer_tb_top;
  // ==========================================================
  // shortened timing keeps the run small
  localparam int ES = 20;
  localparam int EL = 30;
  localparam int WS = 10;
  localparam int WL = 15;
  localparam int UW = 50;
  logic mclk = 1'h0; // system clock
  logic reset = 1'h1; // sync reset
  logic cyc = 1'h0; // bus cycle
  logic stb = 1'h0; // bus strobe
  logic we = 1'h0; // bus direction
  logic [5:0] adr = 6'h0; // register offset
  logic [3:0] sel = 4'h0; // byte lanes
  logic [31:0] wdat = 32'h0; // write data
  logic [31:0] rdat; // read data
  logic ack; // bus answer
  logic fEr; // erase strobe
  logic fPr; // program strobe
  logic [12:0] fAd; // page base
  logic [31:0] tags; // tagged offsets
  logic stall; // cpu hold
  int fail_count = 0;
  int total_checks = 0;
  // key offsets and values in write order
  logic [5:0] keyOfs [6] = '{6'h1c, 6'h24, 6'h2c, 6'h20, 6'h28, 6'h30};
  logic [7:0] keyVal [6] = '{8'h00, 8'h0d, 8'hc3, 8'h04, 8'h09, 8'h40};
  fsps_sequencer #(.ERASE_SHORT(ES), .ERASE_LONG(EL), .WRITE_SHORT(WS),
    .WRITE_LONG(WL), .UNLOCK_WIN(UW)) u_dut (.mclk(mclk), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .flashErase(fEr), .flashProgram(fPr), .flashAddr(fAd),
    .tagMask(tags), .cpuStall(stall));
  // ==========================================================
  // clock, watchdog
  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    finish_test;
  end
  // ==========================================================
  // shared tasks
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= d;
    while (ack !== 1'h1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (n >= 20) begin
      fail_count++;
      finish_test;
    end
  endtask : wb
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd
  task automatic keys(input logic [7:0] last);
    for (int i = 0; i < 6; i++) begin
      wr(keyOfs[i], {24'h0, (i == 5) ? last : keyVal[i]});
    end
  endtask : keys
  // start via go, then measure strobe length and page per cycle
  task automatic run_op(input logic [31:0] c, input logic e,
      input logic [12:0] a, input int len);
    int n;
    wr(6'h00, c);
    n = 0;
    while (stall !== 1'h1 && n < 5) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (stall === 1'h1 && n < 100) begin
      chk({fEr, fPr, fAd}, {e, ~e, a});
      @(negedge mclk);
      n++;
    end
    chk(n, len);
    rd(6'h00, 32'h4, 32'h0);
  endtask : run_op
  // ==========================================================
  // scenarios
  // buffer clear, polled until the bit self-clears; also sets dursel 0
  task automatic clr_buf;
    logic [31:0] q;
    int n;
    n = 0;
    wr(6'h08, 32'h1);
    do begin
      wb(1'h0, 6'h08, 32'h0, q);
      n++;
    end while (q[0] !== 1'h0 && n < 40);
    chk(q, 32'h0);
    chk(tags, 32'h0);
  endtask : clr_buf
  task automatic t_locked;
    rd(6'h00, 32'hff, 32'h0);
    rd(6'h3c, 32'hffffffff, 32'h0);
    run_op(32'h15, 1'h1, 13'h0, 0);
  endtask : t_locked
  task automatic t_unlock;
    wr(6'h00, 32'h68);
    rd(6'h00, 32'h8, 32'h8);
    keys(8'h41);
    rd(6'h00, 32'h1, 32'h0);
    repeat (UW) @(posedge mclk);
    rd(6'h00, 32'h8, 32'h0);
    keys(8'h40);
    rd(6'h00, 32'h1, 32'h0);
    // spoil the stored pattern so the match must come after arming
    wr(6'h30, 32'h41);
    wr(6'h00, 32'h68);
    rd(6'h00, 32'h1, 32'h0);
    keys(8'h40);
    rd(6'h00, 32'h1, 32'h1);
  endtask : t_unlock
  task automatic t_erase;
    clr_buf;
    wr(6'h0c, 32'hbc);
    wr(6'h10, 32'h0a);
    for (int i = 0; i < 6; i++) begin
      wr(6'h18, 32'h0);
    end
    chk(tags, 32'hf0000000);
    run_op(32'h15, 1'h1, 13'h0aa0, ES);
    chk(tags, 32'h0);
  endtask : t_erase
  task automatic t_write;
    wr(6'h0c, 32'ha0);
    wr(6'h14, 32'h5a);
    wr(6'h18, 32'ha5);
    wr(6'h14, 32'h11);
    chk(tags, 32'h1);
    wr(6'h18, 32'h22);
    chk(tags, 32'h3);
    wr(6'h08, 32'h2);
    run_op(32'h05, 1'h0, 13'h0aa0, WL);
    run_op(32'h15, 1'h1, 13'h0aa0, EL);
    clr_buf;
    wr(6'h0c, 32'ha5);
    wr(6'h14, 32'h33);
    wr(6'h18, 32'h44);
    chk(tags, 32'h20);
    run_op(32'h05, 1'h0, 13'h0aa0, WS);
  endtask : t_write
  task automatic t_disable;
    wr(6'h00, 32'h00);
    rd(6'h00, 32'h1, 32'h0);
    run_op(32'h15, 1'h1, 13'h0, 0);
  endtask : t_disable
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    t_locked;
    t_unlock;
    t_erase;
    t_write;
    t_disable;
    finish_test;
  end
endmodule : fsps_sequencer_tb_top
